// [shared/refcmd_pkg.sv]
/*
 * Constants, field layouts and enums for the engine reference command former.
 * Assumes one core clock, an asynchronous active-high reset, and an engine of four threads.
 */
// Summary of operation
// - completion token raises a signal event for the issuing thread when done
// - swap token requests a signal and sleeps the thread until it arrives
// - branch tests pending events; arbitration sleeps thread until any event
// - host DMA requests queue four deep, five outstanding with one active channel, six with both
// - DMA goes to first free channel or forced channel two, in order
// - maskable channels-not-busy interrupt when both channels are idle and the queue is empty
// - fast write carries a 10-bit immediate inside the command
// - inter-thread signal write takes immediate as thread number 0 to 23
// - completion write shifts 2-bit message by writer; bump variants count sequence
// - transmit-validate write marks queue element 0 to 15 valid
// - writing one to an enqueue bump register adds exactly one
// - self-clearing flag write sets the bit selected 0 to 31
// - interrupt flag write shifts bits 6:0 by thread, bits 9:7 fixed
// - ALU result latched each instruction; indirect token rewrites command from it
// - one override bit per field; token enables mux, bits pick fields
// - transmit-queue write: override enable bit 20, burst minus one in 19:16
// - dynamic memory: override thread, transfer register, quadword count, byte mask
// - static memory: override thread, register, count, list register, set/clear, return
// - scratchpad write: override thread, longword count, source transfer register
// - commands enter a two-entry queue; full queue stalls execution
`default_nettype none
package refcmd_pkg;
    localparam int THREADS = 4;
    localparam int TID_W = 2;
    localparam int ENGINE_THREAD_W = 5;
    localparam int MAX_THREAD_NUM = 23;
    localparam int IMM_W = 10;
    localparam int CMDQ_DEPTH = 2;
    localparam int DMAQ_DEPTH = 4;
    localparam int DMA_MAX_OUT = 5;
    localparam int CNT_W = 4;

    // functional unit targets
    typedef enum logic [2:0] {
        UNIT_DRAM = 3'h0,
        UNIT_SRAM = 3'h1,
        UNIT_FBUS = 3'h2,
        UNIT_HOST = 3'h3
    } unit_e;

    // operations, shared between units
    typedef enum logic [3:0] {
        OP_READ = 4'h0,
        OP_WRITE = 4'h1,
        OP_TQ_WR = 4'h2,
        OP_RQ_WR = 4'h3,
        OP_PUSH_POP = 4'h4,
        OP_BIT_WR = 4'h5,
        OP_FAST_WR = 4'h6,
        OP_DMA = 4'h7
    } op_e;

    // fast write targets
    typedef enum logic [3:0] {
        FW_INTER_SIG = 4'h0,
        FW_DONE = 4'h1,
        FW_DONE_BUMP1 = 4'h2,
        FW_DONE_BUMP2 = 4'h3,
        FW_XMIT_VALID = 4'h4,
        FW_ENQ_BUMP1 = 4'h5,
        FW_ENQ_BUMP2 = 4'h6,
        FW_SELF_CLR = 4'h7,
        FW_IRQ_FLAG = 4'h8
    } fw_e;

    // thread state, one-hot
    typedef enum logic [1:0] {
        TH_RUN = 2'b01,
        TH_SLEEP = 2'b10
    } thread_e;

    // indirect data layout
    localparam int IND_TQ_OVR_BIT = 20;
    localparam int IND_TQ_BURST_HI = 19;
    localparam int IND_TQ_BURST_LO = 16;
    localparam int IND_OVR_TID = 31;
    localparam int IND_OVR_XREG = 30;
    localparam int IND_OVR_CNT = 29;
    localparam int IND_OVR_MASK = 28;
    localparam int IND_OVR_AUX = 27;
    localparam int IND_OVR_IMM = 26;
    localparam int IND_TID_LO = 21;
    localparam int IND_XREG_LO = 0;
    localparam int IND_CNT_LO = 16;
    localparam int IND_MASK_LO = 8;
    localparam int IND_AUX_LO = 5;
    localparam int IND_IMM_LO = 0;

    // fast write immediate segments
    localparam int IRQ_LOW_W = 7;
    localparam int IRQ_HIGH_LO = 7;
    localparam int IRQ_HIGH_W = 3;
    localparam int MSG_W = 2;
endpackage
`default_nettype wire

// [hdl/ref_cmd_former.sv]
/*
 * Reference command former for one processing engine: indirect override,
 * two-entry command queue, thread signal/sleep, frame bus fast writes and
 * the host-bus DMA request queue with two channels.
 * Assumes functional units report completion with unit-neutral done pulses
 * and that reference instruction fields arrive decoded on plain ports.
 */
`timescale 1ns/1ns
`default_nettype none
module ref_cmd_former
    import refcmd_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    // instruction side
    input wire logic [TID_W-1:0] cur_thread,
    input wire logic alu_valid,
    input wire logic [31:0] alu_result,
    input wire logic ref_valid,
    input wire unit_e ref_unit,
    input wire op_e ref_op,
    input wire logic [4:0] ref_xreg,
    input wire logic [CNT_W-1:0] ref_count,
    input wire logic [7:0] ref_mask,
    input wire logic [2:0] ref_aux,
    input wire logic [IMM_W-1:0] ref_imm,
    input wire fw_e ref_fw_target,
    input wire logic tok_sig_done,
    input wire logic tok_swap,
    input wire logic tok_indirect,
    input wire logic tok_force_ch2,
    input wire logic arb_valid,
    input wire logic br_valid,
    output logic stall,
    output logic branch_if_no_event,
    output logic [THREADS-1:0] thread_awake,
    // command bus side
    output logic cmd_valid,
    input wire logic cmd_ready,
    output logic [45:0] cmd_data,
    // completions from functional units
    input wire logic done_valid,
    input wire logic [TID_W-1:0] done_thread,
    // frame bus unit fast write results
    input wire logic [2:0] engine_id,
    output logic [23:0] inter_sig_q,
    output logic [23:0] done_msg_q,
    output logic [7:0] enq_seq1_q,
    output logic [7:0] enq_seq2_q,
    output logic [15:0] xmit_valid_q,
    output logic [31:0] self_clr_q,
    output logic [23:0] irq_flag_q,
    output logic [2:0] fixed_position_bit_two,
    input wire logic [15:0] xmit_valid_clr,
    input wire logic self_clr_ack,
    // host bus DMA
    input wire logic dma_both_owned,
    input wire logic [1:0] ch_done,
    output logic [1:0] ch_busy_q,
    output logic [2:0] dma_depth,
    input wire logic not_busy_en,
    output logic not_busy_irq
);

    ////////////////////////////////////////////////////////////////////////
    // indirect override
    logic [31:0] alu_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) alu_q <= 32'h0000_0000;
        else if (alu_valid) alu_q <= alu_result;
    end

    wire ind = tok_indirect;
    wire tq_op = (ref_op == OP_TQ_WR);
    wire o_tid = ind && alu_q[IND_OVR_TID];
    wire o_xreg = ind && alu_q[IND_OVR_XREG];
    wire o_cnt = ind && (tq_op ? alu_q[IND_TQ_OVR_BIT] : alu_q[IND_OVR_CNT]);
    wire o_mask = ind && alu_q[IND_OVR_MASK] && (ref_unit == UNIT_DRAM);
    wire o_aux = ind && alu_q[IND_OVR_AUX] && (ref_unit == UNIT_SRAM);
    wire o_imm = ind && alu_q[IND_OVR_IMM] && (ref_op == OP_FAST_WR);
    // clear override bits keep instruction fields
    wire [ENGINE_THREAD_W-1:0] f_tid = o_tid ? alu_q[IND_TID_LO +: ENGINE_THREAD_W]
                                             : {engine_id, cur_thread};
    wire [4:0] f_xreg = o_xreg ? alu_q[IND_XREG_LO +: 5] : ref_xreg;
    wire [CNT_W-1:0] f_cnt = !o_cnt ? ref_count
                           : tq_op ? alu_q[IND_TQ_BURST_HI:IND_TQ_BURST_LO]
                           : alu_q[IND_CNT_LO +: CNT_W];
    wire [7:0] f_mask = o_mask ? alu_q[IND_MASK_LO +: 8] : ref_mask;
    wire [2:0] f_aux = o_aux ? alu_q[IND_AUX_LO +: 3] : ref_aux;
    wire [IMM_W-1:0] f_imm = o_imm ? alu_q[IND_IMM_LO +: IMM_W] : ref_imm;
    wire [45:0] new_cmd = {ref_unit, ref_op, ref_fw_target, f_tid, f_xreg, f_cnt,
                           f_mask, f_aux, f_imm};

    ////////////////////////////////////////////////////////////////////////
    // two-entry command queue; full queue stalls the engine
    logic [45:0] cq_mem [CMDQ_DEPTH];
    // force token travels with its command, the engine has moved on by the pop
    logic cq_force_q [CMDQ_DEPTH];
    logic [1:0] cq_cnt_q;
    logic cq_wp_q;
    logic cq_rp_q;
    wire cq_full = (cq_cnt_q == 2'(CMDQ_DEPTH));
    wire cq_push = ref_valid && !cq_full;
    wire cq_pop = cmd_valid && cmd_ready;
    assign stall = ref_valid && cq_full;
    assign cmd_valid = (cq_cnt_q != 2'h0);
    assign cmd_data = cq_mem[cq_rp_q];
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cq_cnt_q <= 2'h0;
            cq_wp_q <= 1'b0;
            cq_rp_q <= 1'b0;
        end else begin
            cq_cnt_q <= cq_cnt_q + 2'(cq_push) - 2'(cq_pop);
            if (cq_push) cq_wp_q <= !cq_wp_q;
            if (cq_pop) cq_rp_q <= !cq_rp_q;
        end
    end
    always_ff @(posedge clock) begin
        if (cq_push) begin
            cq_mem[cq_wp_q] <= new_cmd;
            cq_force_q[cq_wp_q] <= tok_force_ch2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // thread signal events and sleep
    logic [THREADS-1:0] ev_q;
    logic [THREADS-1:0] want_q;
    thread_e th_q [THREADS];
    wire [THREADS-1:0] req_sig = {THREADS{cq_push && (tok_sig_done || tok_swap)}}
                                 & (4'h1 << cur_thread);
    wire [THREADS-1:0] done_hit = {THREADS{done_valid}} & (4'h1 << done_thread);
    wire [THREADS-1:0] ev_set = done_hit & want_q;
    wire [THREADS-1:0] cur_mask = 4'h1 << cur_thread;
    wire do_sleep = (cq_push && tok_swap) || arb_valid;
    assign branch_if_no_event = br_valid && !ev_q[cur_thread];
    genvar gi;
    generate
        for (gi = 0; gi < THREADS; gi++) begin : g_th
            assign thread_awake[gi] = (th_q[gi] == TH_RUN);
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    th_q[gi] <= TH_RUN;
                    ev_q[gi] <= 1'b0;
                    want_q[gi] <= 1'b0;
                end else begin
                    if (req_sig[gi]) want_q[gi] <= 1'b1;
                    else if (ev_set[gi]) want_q[gi] <= 1'b0;
                    // event set wins over the consuming clear
                    if (ev_set[gi]) ev_q[gi] <= 1'b1;
                    else if (th_q[gi] == TH_SLEEP) ev_q[gi] <= 1'b0;
                    else if (br_valid && cur_mask[gi]) ev_q[gi] <= 1'b0;
                    case (th_q[gi])
                        TH_RUN: if (do_sleep && cur_mask[gi]) th_q[gi] <= TH_SLEEP;
                        TH_SLEEP: if (ev_set[gi] || ev_q[gi]) th_q[gi] <= TH_RUN;
                        default: th_q[gi] <= TH_RUN;
                    endcase
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // frame bus unit fast write decode
    wire fw_go = cq_pop && (cmd_data[45:43] == UNIT_FBUS)
                 && (cmd_data[42:39] == OP_FAST_WR);
    wire [3:0] fw_tgt = cmd_data[38:35];
    wire [ENGINE_THREAD_W-1:0] fw_tid = cmd_data[34:30];
    wire [IMM_W-1:0] fw_imm = cmd_data[IMM_W-1:0];
    wire is_t = fw_go;
    wire sig_ok = is_t && fw_tgt == FW_INTER_SIG && fw_imm <= 10'(MAX_THREAD_NUM);
    wire done_w = is_t && (fw_tgt == FW_DONE || fw_tgt == FW_DONE_BUMP1
                           || fw_tgt == FW_DONE_BUMP2);
    wire bump1 = is_t && ((fw_tgt == FW_DONE_BUMP1)
                 || (fw_tgt == FW_ENQ_BUMP1 && fw_imm == 10'h001));
    wire bump2 = is_t && ((fw_tgt == FW_DONE_BUMP2)
                 || (fw_tgt == FW_ENQ_BUMP2 && fw_imm == 10'h001));
    wire xv_w = is_t && fw_tgt == FW_XMIT_VALID;
    wire sc_w = is_t && fw_tgt == FW_SELF_CLR;
    wire irq_w = is_t && fw_tgt == FW_IRQ_FLAG;
    wire [5:0] msg_pos = 6'(fw_tid) * 6'(MSG_W);
    wire [23:0] msg_bits = 24'(fw_imm[MSG_W-1:0]) << msg_pos;
    wire [23:0] msg_keep = ~(24'h00_0003 << msg_pos);
    wire [23:0] irq_bits = 24'(fw_imm[IRQ_LOW_W-1:0]) << fw_tid;
    wire [15:0] xv_set = xv_w ? (16'h0001 << fw_imm[3:0]) : 16'h0000;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            inter_sig_q <= 24'h00_0000;
            done_msg_q <= 24'h00_0000;
            enq_seq1_q <= 8'h00;
            enq_seq2_q <= 8'h00;
            xmit_valid_q <= 16'h0000;
            self_clr_q <= 32'h0000_0000;
            irq_flag_q <= 24'h00_0000;
            fixed_position_bit_two <= 3'h0;
        end else begin
            inter_sig_q <= sig_ok ? (24'h00_0001 << fw_imm[4:0]) : 24'h00_0000;
            if (done_w) done_msg_q <= (done_msg_q & msg_keep) | msg_bits;
            if (bump1) enq_seq1_q <= enq_seq1_q + 8'h01;
            if (bump2) enq_seq2_q <= enq_seq2_q + 8'h01;
            // set wins over the consumer's clear
            xmit_valid_q <= (xmit_valid_q & ~xmit_valid_clr) | xv_set;
            if (sc_w) self_clr_q <= self_clr_q | (32'h0000_0001 << fw_imm[4:0]);
            else if (self_clr_ack) self_clr_q <= 32'h0000_0000;
            if (irq_w) begin
                irq_flag_q <= irq_flag_q | irq_bits;
                fixed_position_bit_two <= fw_imm[IRQ_HIGH_LO +: IRQ_HIGH_W];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // host bus DMA: four queued plus one active per channel; no full flag by design,
    // overflow drops the request and software must keep the count
    logic [1:0] dq_ch2_q [DMAQ_DEPTH];
    logic [2:0] dq_cnt_q;
    wire dma_go = cq_pop && (cmd_data[45:43] == UNIT_HOST);
    wire head_force = cq_force_q[cq_rp_q];
    wire head_ch2 = dq_ch2_q[0][0];
    wire can_ch2 = !ch_busy_q[1] && dma_both_owned;
    wire can_any = !ch_busy_q[0] || can_ch2;
    // forced requests wait for channel two, so they finish in issue order
    wire issue = (dq_cnt_q != 3'h0) && (head_ch2 ? can_ch2 : can_any);
    wire to_ch1 = issue && !head_ch2 && !ch_busy_q[0];
    wire to_ch2 = issue && !to_ch1;
    wire dq_push = dma_go && (dq_cnt_q < 3'(DMAQ_DEPTH) || issue);
    wire [2:0] dq_after = dq_cnt_q - 3'(issue);
    assign dma_depth = dq_cnt_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dq_cnt_q <= 3'h0;
            ch_busy_q <= 2'b00;
            for (int i = 0; i < DMAQ_DEPTH; i++) dq_ch2_q[i] <= 2'b00;
        end else begin
            if (issue) begin
                for (int i = 0; i < DMAQ_DEPTH - 1; i++) dq_ch2_q[i] <= dq_ch2_q[i+1];
            end
            if (dq_push) dq_ch2_q[dq_after[1:0]] <= {1'b0, head_force && dma_both_owned};
            dq_cnt_q <= dq_after + 3'(dq_push);
            ch_busy_q[0] <= to_ch1 || (ch_busy_q[0] && !ch_done[0]);
            ch_busy_q[1] <= to_ch2 || (ch_busy_q[1] && !ch_done[1]);
        end
    end
    assign not_busy_irq = not_busy_en && (ch_busy_q == 2'b00) && (dq_cnt_q == 3'h0);

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_stall_full;
        @(posedge clock) disable iff (rst) (ref_valid && cq_cnt_q == 2'h2) |-> stall;
    endproperty
    a_stall_full: assert property (p_stall_full) else $error("no stall on full queue");

    property p_swap_sleep;
        @(posedge clock) disable iff (rst)
        (cq_push && tok_swap && !ev_set[cur_thread]) |=> !thread_awake[$past(cur_thread)];
    endproperty
    a_swap_sleep: assert property (p_swap_sleep) else $error("swap did not sleep");

    property p_event_wake;
        @(posedge clock) disable iff (rst)
        (th_q[done_thread] == TH_SLEEP && ev_set[done_thread])
        |=> thread_awake[$past(done_thread)];
    endproperty
    a_event_wake: assert property (p_event_wake) else $error("event did not wake");

    property p_branch;
        @(posedge clock) disable iff (rst)
        br_valid |-> (branch_if_no_event == !ev_q[cur_thread]);
    endproperty
    a_branch: assert property (p_branch) else $error("branch ignores events");

    property p_seq_step;
        @(posedge clock) disable iff (rst) bump1 |=> enq_seq1_q == $past(enq_seq1_q) + 8'h01;
    endproperty
    a_seq_step: assert property (p_seq_step) else $error("sequence not bumped by one");

    property p_xv_mark;
        @(posedge clock) disable iff (rst) xv_w |=> xmit_valid_q[$past(fw_imm[3:0])];
    endproperty
    a_xv_mark: assert property (p_xv_mark) else $error("element not marked valid");

    property p_keep_fields;
        @(posedge clock) disable iff (rst)
        (ref_valid && !tok_indirect) |-> (f_xreg == ref_xreg && f_cnt == ref_count);
    endproperty
    a_keep_fields: assert property (p_keep_fields) else $error("field overridden");

    property p_dma_bound;
        @(posedge clock) disable iff (rst) dq_cnt_q <= 3'(DMAQ_DEPTH);
    endproperty
    a_dma_bound: assert property (p_dma_bound) else $error("dma queue overflow");

    property p_irq_high;
        @(posedge clock) disable iff (rst)
        irq_w |=> fixed_position_bit_two == $past(fw_imm[9:7]);
    endproperty
    a_irq_high: assert property (p_irq_high) else $error("fixed bits wrong");

    property p_sig_range;
        @(posedge clock) disable iff (rst)
        (is_t && fw_tgt == FW_INTER_SIG && fw_imm > 10'(MAX_THREAD_NUM))
        |=> inter_sig_q == 24'h00_0000;
    endproperty
    a_sig_range: assert property (p_sig_range) else $error("signal out of range");

    property p_sc_set;
        @(posedge clock) disable iff (rst) sc_w |=> self_clr_q[$past(fw_imm[4:0])];
    endproperty
    a_sc_set: assert property (p_sc_set) else $error("flag bit not set");

    property p_ch2_owned;
        @(posedge clock) disable iff (rst) to_ch2 |-> dma_both_owned;
    endproperty
    a_ch2_owned: assert property (p_ch2_owned) else $error("channel two not owned");

    property p_cmd_hold;
        @(posedge clock) disable iff (rst)
        (cmd_valid && !cmd_ready) |=> (cmd_valid && $stable(cmd_data));
    endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("command not held");
endmodule
`default_nettype wire

// [test/unit_model.sv]
/*
 * Behavioural model of the shared functional units facing the command former:
 * takes commands, returns completion pulses, runs the host-bus DMA channels.
 * Assumes the bench picks readiness, channel progress and the completing thread.
 */
`timescale 1ns/1ns
`default_nettype none
module unit_model
    import refcmd_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic cmd_valid,
    output logic cmd_ready,
    output logic done_valid,
    output logic [TID_W-1:0] done_thread,
    input wire logic [1:0] ch_busy_q,
    output logic [1:0] ch_done,
    input wire logic ready_en,
    input wire logic ch_run,
    input wire logic [TID_W-1:0] resp_thread
);
    logic [2:0] pop_q;
    // slow mode: ready held low keeps commands queued in the engine
    assign cmd_ready = ready_en;
    assign done_valid = pop_q[2];
    assign done_thread = resp_thread;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pop_q <= 3'h0;
            ch_done <= 2'h0;
        end else begin
            pop_q <= {pop_q[1:0], cmd_valid & cmd_ready};
            // a channel finishes one cycle after start at the earliest
            ch_done <= {2{ch_run}} & ch_busy_q & ~ch_done;
        end
    end
endmodule
`default_nettype wire

// [test/test_engine_reference_command_former.sv]
/*
 * Self-checking bench for the reference command former.
 * Assumes the unit model answers commands; inputs change on falling edges.
 */
`timescale 1ns/1ns
`default_nettype none
module test_engine_reference_command_former
    import refcmd_pkg::*;
;
    logic clock, rst, alu_valid, ref_valid, arb_valid, br_valid, stall, branch_if_no_event;
    logic tok_sig_done, tok_swap, tok_indirect, tok_force_ch2, cmd_valid, cmd_ready, done_valid;
    logic dma_both_owned, not_busy_en, not_busy_irq, self_clr_ack, ready_en, ch_run;
    logic [TID_W-1:0] cur_thread, done_thread, resp_thread;
    logic [31:0] alu_result, self_clr_q;
    unit_e ref_unit;
    op_e ref_op;
    fw_e ref_fw_target;
    logic [9:0] ref_imm;
    logic [3:0] thread_awake, ref_count;
    logic [45:0] cmd_data;
    logic [23:0] inter_sig_q, done_msg_q, irq_flag_q, sig_seen;
    logic [7:0] enq_seq1_q, enq_seq2_q;
    logic [15:0] xmit_valid_q;
    logic [2:0] fixed_position_bit_two, dma_depth;
    logic [1:0] ch_done, ch_busy_q;
    int n_fail, total_checks;

    ref_cmd_former u_ref_cmd_former (.clock(clock), .rst(rst), .cur_thread(cur_thread),
        .alu_valid(alu_valid), .alu_result(alu_result), .ref_valid(ref_valid),
        .ref_unit(ref_unit), .ref_op(ref_op), .ref_xreg(5'h00), .ref_count(ref_count),
        .ref_mask(8'h00), .ref_aux(3'h0), .ref_imm(ref_imm), .ref_fw_target(ref_fw_target),
        .tok_sig_done(tok_sig_done), .tok_swap(tok_swap), .tok_indirect(tok_indirect),
        .tok_force_ch2(tok_force_ch2), .arb_valid(arb_valid), .br_valid(br_valid),
        .stall(stall), .branch_if_no_event(branch_if_no_event), .thread_awake(thread_awake),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_data(cmd_data),
        .done_valid(done_valid), .done_thread(done_thread), .engine_id(3'h0),
        .inter_sig_q(inter_sig_q), .done_msg_q(done_msg_q), .enq_seq1_q(enq_seq1_q),
        .enq_seq2_q(enq_seq2_q), .xmit_valid_q(xmit_valid_q), .self_clr_q(self_clr_q),
        .irq_flag_q(irq_flag_q), .fixed_position_bit_two(fixed_position_bit_two),
        .xmit_valid_clr(16'h0000), .self_clr_ack(self_clr_ack),
        .dma_both_owned(dma_both_owned), .ch_done(ch_done), .ch_busy_q(ch_busy_q),
        .dma_depth(dma_depth), .not_busy_en(not_busy_en), .not_busy_irq(not_busy_irq));

    unit_model u_unit_model (.clock(clock), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .done_valid(done_valid), .done_thread(done_thread),
        .ch_busy_q(ch_busy_q), .ch_done(ch_done), .ready_en(ready_en), .ch_run(ch_run),
        .resp_thread(resp_thread));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // inter-thread signals are one-cycle pulses, so collect them
    always @(posedge clock) sig_seen <= sig_seen | inter_sig_q;

    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // holds the reference while stalled, as a stalled engine would
    task automatic issue(input unit_e u, input op_e o, input fw_e t, input logic [9:0] imm,
            input logic [3:0] tk);
        logic s;
        @(negedge clock);
        {ref_unit, ref_op, ref_fw_target, ref_imm} = {u, o, t, imm};
        {tok_sig_done, tok_swap, tok_indirect, tok_force_ch2} = tk;
        ref_valid = 1'b1;
        for (int i = 0; i < 60; i++) begin
            #1 s = stall;
            @(posedge clock);
            if (s === 1'b0) break;
            if (i == 59) begin n_fail++; stop_test(); end
            @(negedge clock);
        end
        @(negedge clock);
        ref_valid = 1'b0;
        {tok_sig_done, tok_swap, tok_indirect, tok_force_ch2} = 4'h0;
    endtask
    task automatic until_idle();
        for (int i = 0; i < 200 && (cmd_valid !== 1'b0 || ch_busy_q !== 2'h0
                || dma_depth !== 3'h0); i++) @(negedge clock);
        if (cmd_valid !== 1'b0 || ch_busy_q !== 2'h0 || dma_depth !== 3'h0) begin
            n_fail++;
            stop_test();
        end
        // completion arrives three cycles after the pop
        repeat (4) @(negedge clock);
    endtask
    task automatic fast(input fw_e t, input logic [9:0] imm, input logic ind);
        issue(UNIT_FBUS, OP_FAST_WR, t, imm, {2'b00, ind, 1'b0});
        until_idle();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_fast_writes();
        // only the bits each target needs are written
        cur_thread = 2'h2;
        sig_sig: begin fast(FW_INTER_SIG, 10'h017, 1'b0); end
        check(sig_seen, 24'h80_0000);
        fast(FW_INTER_SIG, 10'h018, 1'b0);
        check(sig_seen, 24'h80_0000);
        fast(FW_XMIT_VALID, 10'h00f, 1'b0);
        check(xmit_valid_q, 16'h8000);
        fast(FW_ENQ_BUMP1, 10'h001, 1'b0);
        fast(FW_ENQ_BUMP2, 10'h002, 1'b0);
        check({enq_seq1_q, enq_seq2_q}, 16'h0100);
        fast(FW_SELF_CLR, 10'h01f, 1'b0);
        check(self_clr_q, 32'h8000_0000);
        fast(FW_IRQ_FLAG, 10'h283, 1'b0);
        check({fixed_position_bit_two, irq_flag_q}, 32'h0500_000c);
        cur_thread = 2'h1;
        fast(FW_DONE_BUMP1, 10'h002, 1'b0);
        check({done_msg_q, enq_seq1_q}, 32'h0000_0802);
    endtask
    task automatic t_indirect();
        @(negedge clock);
        {self_clr_ack, alu_valid, alu_result} = {2'b11, 32'h0400_0005};
        @(negedge clock);
        {self_clr_ack, alu_valid} = 2'b00;
        fast(FW_SELF_CLR, 10'h009, 1'b1);
        check(self_clr_q, 32'h0000_0020);
        @(negedge clock);
        {alu_valid, alu_result} = {1'b1, 32'h0000_0005};
        @(negedge clock);
        alu_valid = 1'b0;
        fast(FW_SELF_CLR, 10'h007, 1'b1);
        check(self_clr_q, 32'h0000_00a0);
        {ready_en, alu_valid, alu_result, ref_count} = {2'h1, 32'h0013_0000, 4'h9};
        @(negedge clock);
        alu_valid = 1'b0;
        issue(UNIT_DRAM, OP_TQ_WR, FW_INTER_SIG, 10'h000, 4'h2);
        check(cmd_data[24:21], 4'h3);
        ready_en = 1'b1;
        until_idle();
    endtask
    task automatic t_queue_full();
        ready_en = 1'b0;
        issue(UNIT_SRAM, OP_READ, FW_DONE, 10'h000, 4'h0);
        issue(UNIT_SRAM, OP_READ, FW_DONE, 10'h000, 4'h0);
        @(negedge clock);
        ref_valid = 1'b1;
        #1 check(stall, 1'b1);
        ready_en = 1'b1;
        // stalled reference held until the queue takes it
        repeat (2) @(negedge clock);
        ref_valid = 1'b0;
        until_idle();
    endtask
    task automatic t_signals();
        cur_thread = 2'h0;
        resp_thread = 2'h0;
        issue(UNIT_DRAM, OP_WRITE, FW_DONE, 10'h000, 4'h8);
        until_idle();
        @(negedge clock);
        br_valid = 1'b1;
        #1 check(branch_if_no_event, 1'b0);
        @(negedge clock);
        #1 check(branch_if_no_event, 1'b1);
        br_valid = 1'b0;
        {cur_thread, resp_thread} = 4'h5;
        issue(UNIT_SRAM, OP_READ, FW_DONE, 10'h000, 4'h4);
        check(thread_awake, 4'hd);
        until_idle();
        check(thread_awake, 4'hf);
        {cur_thread, resp_thread, ready_en} = 5'h14;
        issue(UNIT_SRAM, OP_READ, FW_DONE, 10'h000, 4'h8);
        @(negedge clock);
        arb_valid = 1'b1;
        @(negedge clock);
        {arb_valid, ready_en} = 2'b01;
        check(thread_awake, 4'hb);
        until_idle();
        check(thread_awake, 4'hf);
    endtask
    task automatic t_dma();
        // at most five requests pending, channels drained before reassignment
        {dma_both_owned, ch_run} = 2'b00;
        repeat (5) issue(UNIT_HOST, OP_DMA, FW_DONE, 10'h000, 4'h0);
        repeat (3) @(negedge clock);
        check({ch_busy_q, dma_depth}, 5'h0c);
        ch_run = 1'b1;
        until_idle();
        not_busy_en = 1'b1;
        #1 check(not_busy_irq, 1'b1);
        not_busy_en = 1'b0;
        #1 check(not_busy_irq, 1'b0);
        {dma_both_owned, ch_run} = 2'b10;
        issue(UNIT_HOST, OP_DMA, FW_DONE, 10'h000, 4'h1);
        repeat (3) @(negedge clock);
        check(ch_busy_q, 2'h2);
        ch_run = 1'b1;
        until_idle();
    endtask

    initial begin
        {rst, alu_valid, ref_valid, arb_valid, br_valid, self_clr_ack} = 6'h20;
        {tok_sig_done, tok_swap, tok_indirect, tok_force_ch2} = 4'h0;
        {dma_both_owned, not_busy_en, ready_en, ch_run} = 4'h3;
        {cur_thread, resp_thread, alu_result, ref_imm, sig_seen, ref_count} = '0;
        {ref_unit, ref_op, ref_fw_target} = {UNIT_DRAM, OP_READ, FW_INTER_SIG};
        {n_fail, total_checks} = '0;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        check(self_clr_q, 32'h0000_0000);
        check({thread_awake, cmd_valid}, 5'h1e);
        t_fast_writes();
        t_indirect();
        t_queue_full();
        t_signals();
        t_dma();
        stop_test();
    end
endmodule
`default_nettype wire
